// ---- hdl/lpbsm_pkg.sv ----
/*
 lpbsm_pkg: commands, bank and device states, timing counts and shared
 decoding for the bank/power state machine of a low power DDR memory.
 Assumes a 125 MHz sys_clk; the command bus is already decoded to commands.
*/
package lpbsm_pkg;
	localparam int NBANK = 8;
	localparam int CLK_PS = 8000;
	// timings in picoseconds, rounded up to whole cycles
	localparam int T_RCD_PS = 18000;
	localparam int T_RP_PS = 21000;
	localparam int T_RFCPB_PS = 60000;
	localparam int T_RFCAB_PS = 130000;
	localparam int T_XP_PS = 7500;
	localparam int T_XSR_PS = 140000;
	localparam int T_INIT5_PS = 10000000;
	localparam logic [7:0] RCD_CYC = 8'((T_RCD_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] RP_CYC = 8'((T_RP_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] RFCPB_CYC = 8'((T_RFCPB_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] RFCAB_CYC = 8'((T_RFCAB_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] XP_CYC = 8'((T_XP_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] XSR_CYC = 8'((T_XSR_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [10:0] INIT5_CYC = 11'((T_INIT5_PS + CLK_PS - 1) / CLK_PS);
	// timings given directly in cycles
	localparam logic [7:0] MRR_CYC = 8'h02;
	localparam logic [7:0] MRW_CYC = 8'h05;
	localparam logic [7:0] BURST_CYC = 8'h04;

	typedef enum logic [3:0] {
		CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF_PB, CMD_REF_AB,
		CMD_MRW, CMD_MRR, CMD_RESET, CMD_BST, CMD_SREF, CMD_DPD
	} lpbsm_cmd_t;

	typedef enum logic [3:0] {
		B_IDLE, B_ACTIVATING, B_ACTIVE, B_READING, B_WRITING, B_RD_AP, B_WR_AP,
		B_PRECHARGING, B_REFRESHING, B_MRR_IDLE, B_MRR_ACT
	} lpbsm_bank_t;

	typedef enum logic [3:0] {
		DS_POWER_ON, DS_RESETTING, DS_RST_MRR, DS_RUN, DS_APD, DS_IPD, DS_RPD,
		DS_SREF, DS_DPD, DS_REF_ALL, DS_MRW
	} lpbsm_dev_t;

	// bank commands a bank accepts in its current state
	function automatic logic cmd_ok(lpbsm_bank_t s, lpbsm_cmd_t c);
		case (s)
			B_IDLE: return c inside {CMD_ACT, CMD_PRE, CMD_REF_PB, CMD_MRR};
			B_ACTIVE: return c inside {CMD_RD, CMD_WR, CMD_MRR, CMD_PRE};
			B_READING: return c == CMD_RD;
			B_WRITING: return c == CMD_WR;
			default: return 1'b0;
		endcase
	endfunction

	// length of the nop-only window that follows a command
	function automatic logic [7:0] nop_len(lpbsm_cmd_t c);
		case (c)
			CMD_REF_PB: return RFCPB_CYC;
			CMD_REF_AB: return RFCAB_CYC;
			CMD_MRR: return MRR_CYC;
			CMD_MRW, CMD_RESET: return MRW_CYC;
			default: return 8'h00;
		endcase
	endfunction

	// does a forwarded command address bank idx
	function automatic logic bank_hit(lpbsm_cmd_t c, logic ab, logic [2:0] ba, logic [2:0] idx);
		return (c == CMD_PRE && ab) || (c != CMD_BST && ba == idx);
	endfunction
endpackage

// ---- hdl/lpbsm_if.sv ----
/*
 lpbsm_if: command link between the memory controller end and the device end.
 Assumes both ends share sys_clk; the controller drives every signal.
*/
`timescale 1ns/10ps
interface lpbsm_if;
	import lpbsm_pkg::*;
	logic cke;
	logic cs_n;
	lpbsm_cmd_t cmd;
	logic [2:0] ba;
	logic ap;
	logic ab;
	modport dev (input cke, cs_n, cmd, ba, ap, ab);
	modport ctl (output cke, cs_n, cmd, ba, ap, ab);
endinterface

// ---- hdl/lpbsm_bank.sv ----
/*
 lpbsm_bank: state of one bank with its own timer.
 Assumes only commands legal for the current state are presented with hit.
*/
`timescale 1ns/10ps
module lpbsm_bank (
	input wire logic sys_clk,
	input wire logic rst,
	input wire lpbsm_pkg::lpbsm_cmd_t cmd,
	input wire logic hit,
	input wire logic ap,
	input wire logic bst_hit,
	output lpbsm_pkg::lpbsm_bank_t state
);
	import lpbsm_pkg::*;

	typedef struct packed {
		lpbsm_bank_t st;
		logic [7:0] cnt;
	} lpbsm_bst_t;

	lpbsm_bst_t s_r;
	lpbsm_bst_t s_nxt;
	logic done;

	// next bank state
	always_comb begin
		s_nxt = s_r;
		done = (s_r.cnt == 8'h01);
		if (s_r.cnt != 8'h00) s_nxt.cnt = s_r.cnt - 8'h01;
		unique case (s_r.st)
			B_IDLE, B_ACTIVE, B_READING, B_WRITING: begin
				if (hit && cmd == CMD_ACT) begin
					s_nxt.st = B_ACTIVATING; // R10
					s_nxt.cnt = RCD_CYC;
				end else if (hit && cmd == CMD_PRE) begin
					s_nxt.st = B_PRECHARGING; // R11
					s_nxt.cnt = RP_CYC;
				end else if (hit && cmd == CMD_REF_PB) begin
					s_nxt.st = B_REFRESHING; // R12
					s_nxt.cnt = RFCPB_CYC;
				end else if (hit && cmd == CMD_MRR) begin
					s_nxt.st = (s_r.st == B_IDLE) ? B_MRR_IDLE : B_MRR_ACT; // R14
					s_nxt.cnt = MRR_CYC;
				end else if (hit && cmd == CMD_RD) begin
					s_nxt.st = ap ? B_RD_AP : B_READING; // R17
					s_nxt.cnt = ap ? BURST_CYC + RP_CYC : BURST_CYC; // R21
				end else if (hit && cmd == CMD_WR) begin
					s_nxt.st = ap ? B_WR_AP : B_WRITING; // R17
					s_nxt.cnt = ap ? BURST_CYC + RP_CYC : BURST_CYC; // R21
				end else if (bst_hit) begin
					s_nxt.st = B_ACTIVE; // R20
					s_nxt.cnt = 8'h00;
				end else if (done && s_r.st inside {B_READING, B_WRITING}) begin
					s_nxt.st = B_ACTIVE;
				end
			end
			B_ACTIVATING, B_MRR_ACT: begin
				if (done) s_nxt.st = B_ACTIVE; // R10
			end
			B_RD_AP, B_WR_AP, B_PRECHARGING, B_REFRESHING, B_MRR_IDLE: begin
				if (done) s_nxt.st = B_IDLE; // R21
			end
		endcase
	end

	// state register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_r <= '{st: B_IDLE, cnt: 8'h00};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign state = s_r.st;
endmodule

// ---- hdl/lpbsm_dev.sv ----
/*
 lpbsm_dev: device end; power states chosen by cke, eight bank machines,
 nop-only windows and a violation flag for commands that break them.
 Assumes link signals are synchronous to sys_clk and driven by the controller.
*/
// Notes on behaviour
// (R1) next power state from both cke samples
// (R2) nop with cke fall, banks open: active power down
// (R3) nop with cke fall, banks idle: idle power down
// (R4) self refresh entered idle, exits to idle
// (R5) deep power down exits to power on
// (R6) resetting power down exits by init time
// (R7) only nops until power down exit time
// (R8) clock toggles during exit intervals
// (R9) unlisted state and cke combinations are illegal
// (R10) activate holds bank until row delay met
// (R11) precharge lasts row precharge time, even idle
// (R12) per bank refresh: idle bank, nops after
// (R13) all bank refresh: all idle, nops after
// (R14) mode read returns bank to prior state
// (R15) mode write: all idle, nops, then idle
// (R16) reset starts init from idle or power on
// (R17) active bank takes read, write, mrr, precharge
// (R18) no write into read burst without terminate
// (R19) no read into write burst without terminate
// (R20) burst terminate ends most recent burst
// (R21) auto precharge keeps bank busy then idle
// (R22) other banks obey their own state
// (R23) flag any command in protected windows; self refresh and deep power down entry on a cke fall are not flagged
`timescale 1ns/10ps
module lpbsm_dev (
	input wire logic sys_clk,
	input wire logic rst,
	lpbsm_if.dev link,
	output lpbsm_pkg::lpbsm_dev_t dev_state,
	output lpbsm_pkg::lpbsm_bank_t [lpbsm_pkg::NBANK-1:0] bank_state,
	output logic violation
);
	import lpbsm_pkg::*;

	typedef struct packed {
		lpbsm_dev_t st;
		logic cke_prev;
		logic [7:0] nop;
		logic [10:0] init;
		logic [2:0] last;
		logic viol;
	} lpbsm_dst_t;

	lpbsm_dst_t s_r;
	lpbsm_dst_t s_nxt;
	lpbsm_cmd_t cmd_e;
	lpbsm_cmd_t bcmd;
	logic fwd;
	logic all_idle;
	logic pre_ok;
	logic hi;
	logic fall;
	logic rise;
	logic busy;

	// power and device state, command checking
	always_comb begin
		s_nxt = s_r;
		fwd = 1'b0;
		cmd_e = link.cs_n ? CMD_NOP : link.cmd;
		all_idle = 1'b1;
		pre_ok = 1'b1;
		for (int i = 0; i < NBANK; i++) begin
			all_idle = all_idle & (bank_state[i] == B_IDLE);
			pre_ok = pre_ok & cmd_ok(bank_state[i], CMD_PRE);
		end
		hi = s_r.cke_prev && link.cke; // R1
		fall = s_r.cke_prev && !link.cke;
		rise = !s_r.cke_prev && link.cke;
		busy = (s_r.nop != 8'h00);
		s_nxt.cke_prev = link.cke;
		s_nxt.viol = 1'b0;
		if (busy) s_nxt.nop = s_r.nop - 8'h01;
		if (s_r.init != 11'h000) s_nxt.init = s_r.init - 11'h001;
		if (link.cke && busy && cmd_e != CMD_NOP) s_nxt.viol = 1'b1; // R23
		unique case (s_r.st)
			DS_POWER_ON: begin
				if (hi && !busy && cmd_e == CMD_RESET) begin
					s_nxt.st = DS_RESETTING; // R16
					s_nxt.init = INIT5_CYC;
					s_nxt.nop = nop_len(cmd_e);
				end else if (cmd_e != CMD_NOP) begin
					s_nxt.viol = 1'b1; // R9
				end
			end
			DS_RESETTING: begin
				if (fall && cmd_e == CMD_NOP) begin
					s_nxt.st = DS_RPD; // R6
				end else if (hi && !busy && cmd_e == CMD_MRR) begin
					s_nxt.st = DS_RST_MRR; // R16
					s_nxt.nop = nop_len(cmd_e);
				end else if (cmd_e != CMD_NOP) begin
					s_nxt.viol = 1'b1; // R9
				end else if (s_r.init < 11'h002) begin
					s_nxt.st = DS_RUN;
				end
			end
			DS_RST_MRR: begin
				if (s_r.nop == 8'h01) s_nxt.st = DS_RESETTING; // R14
			end
			DS_REF_ALL, DS_MRW: begin
				if (s_r.nop == 8'h01) s_nxt.st = DS_RUN; // R13 R15
			end
			DS_RUN: begin
				if (fall) begin
					if (cmd_e == CMD_NOP) begin
						s_nxt.st = all_idle ? DS_IPD : DS_APD; // R2 R3
					end else if (cmd_e == CMD_SREF && all_idle) begin
						s_nxt.st = DS_SREF; // R4
					end else if (cmd_e == CMD_DPD && all_idle) begin
						s_nxt.st = DS_DPD; // R5
					end else begin
						s_nxt.viol = 1'b1; // R9
					end
				end else if (hi && !busy && cmd_e != CMD_NOP) begin
					if (cmd_e inside {CMD_REF_AB, CMD_MRW, CMD_RESET}) begin
						if (!all_idle) begin
							s_nxt.viol = 1'b1; // R13 R15
						end else if (cmd_e == CMD_REF_AB) begin
							s_nxt.st = DS_REF_ALL; // R13
						end else if (cmd_e == CMD_MRW) begin
							s_nxt.st = DS_MRW; // R15
						end else begin
							s_nxt.st = DS_RESETTING; // R16
							s_nxt.init = INIT5_CYC;
						end
					end else if (cmd_e == CMD_BST) begin
						fwd = bank_state[s_r.last] inside {B_READING, B_WRITING}; // R20
					end else if (cmd_e == CMD_PRE && link.ab) begin
						fwd = pre_ok; // R11
					end else if (cmd_e inside {CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF_PB, CMD_MRR}) begin
						fwd = cmd_ok(bank_state[link.ba], cmd_e); // R17 R18 R19 R22
					end
					if (!fwd && !(cmd_e inside {CMD_REF_AB, CMD_MRW, CMD_RESET} && all_idle)) begin
						s_nxt.viol = 1'b1; // R23
					end else begin
						s_nxt.nop = nop_len(cmd_e); // R12 R13 R14 R15
					end
					if (fwd && cmd_e inside {CMD_RD, CMD_WR}) s_nxt.last = link.ba; // R20
				end
			end
			DS_APD, DS_IPD, DS_SREF, DS_RPD, DS_DPD: begin
				if (rise && link.cs_n) begin
					s_nxt.nop = (s_r.st == DS_SREF) ? XSR_CYC : XP_CYC; // R7 R4
					unique case (s_r.st)
						DS_APD, DS_IPD, DS_SREF: s_nxt.st = DS_RUN; // R2 R3 R4
						DS_RPD: s_nxt.st = (s_r.init == 11'h000) ? DS_RUN : DS_RESETTING; // R6
						DS_DPD: begin
							s_nxt.st = DS_POWER_ON; // R5
							s_nxt.nop = 8'h00;
						end
					endcase
				end else if (rise) begin
					s_nxt.viol = 1'b1; // R9
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_r <= '{st: DS_POWER_ON, cke_prev: 1'b0, nop: 8'h00, init: 11'h000,
				last: 3'h0, viol: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// bank machines see only accepted commands
	assign bcmd = fwd ? cmd_e : CMD_NOP;
	for (genvar g = 0; g < NBANK; g++) begin : g_bank
		lpbsm_bank u_bank (
			.sys_clk(sys_clk),
			.rst(rst),
			.cmd(bcmd),
			.hit(fwd && bank_hit(cmd_e, link.ab, link.ba, 3'(g))),
			.ap(link.ap),
			.bst_hit(fwd && cmd_e == CMD_BST && s_r.last == 3'(g)),
			.state(bank_state[g])
		);
	end

	assign dev_state = s_r.st;
	assign violation = s_r.viol;
endmodule

// ---- hdl/lpbsm_ctl.sv ----
/*
 lpbsm_ctl: controller end; takes user requests, issues only legal commands,
 inserts nops for protected windows and enters/leaves power down on pd_req.
 Assumes the device end shares sys_clk and samples the link each edge.
*/
`timescale 1ns/10ps
module lpbsm_ctl (
	input wire logic sys_clk,
	input wire logic rst,
	lpbsm_if.ctl link,
	input wire logic req_valid,
	input wire lpbsm_pkg::lpbsm_cmd_t req_cmd,
	input wire logic [2:0] req_ba,
	input wire logic req_ap,
	input wire logic req_ab,
	output logic req_ready,
	input wire logic pd_req,
	output lpbsm_pkg::lpbsm_dev_t ctl_state
);
	import lpbsm_pkg::*;

	typedef struct packed {
		lpbsm_dev_t st;
		logic cke;
		logic cs_n;
		lpbsm_cmd_t cmd;
		logic [2:0] ba;
		logic ap;
		logic ab;
		logic bfwd;
		logic [7:0] nop;
		logic [10:0] init;
		logic [2:0] last;
	} lpbsm_cst_t;

	lpbsm_cst_t s_r;
	lpbsm_cst_t s_nxt;
	lpbsm_bank_t [NBANK-1:0] shadow;
	lpbsm_cmd_t bcmd;
	logic all_idle;
	logic pre_ok;
	logic ok;

	// legality of the request and next link drive
	always_comb begin
		s_nxt = s_r;
		all_idle = 1'b1;
		pre_ok = 1'b1;
		for (int i = 0; i < NBANK; i++) begin
			all_idle = all_idle & (shadow[i] == B_IDLE);
			pre_ok = pre_ok & cmd_ok(shadow[i], CMD_PRE);
		end
		unique case (s_r.st)
			DS_POWER_ON: ok = (req_cmd == CMD_RESET); // R16
			DS_RESETTING: ok = (req_cmd == CMD_MRR);
			DS_RUN: begin
				if (req_cmd inside {CMD_REF_AB, CMD_MRW, CMD_RESET, CMD_SREF, CMD_DPD}) begin
					ok = all_idle; // R13 R15 R4 R5
				end else if (req_cmd == CMD_BST) begin
					ok = shadow[s_r.last] inside {B_READING, B_WRITING};
				end else if (req_cmd == CMD_PRE && req_ab) begin
					ok = pre_ok;
				end else begin
					ok = cmd_ok(shadow[req_ba], req_cmd); // R18 R19 R22
				end
			end
			default: ok = 1'b0;
		endcase
		// one command per two cycles keeps the shadow banks current
		req_ready = ok && s_r.cke && s_r.cs_n && s_r.nop == 8'h00 &&
			(!pd_req || req_cmd inside {CMD_SREF, CMD_DPD}); // R7 R9
		s_nxt.cs_n = 1'b1;
		s_nxt.cmd = CMD_NOP;
		s_nxt.bfwd = 1'b0;
		if (s_r.nop != 8'h00) s_nxt.nop = s_r.nop - 8'h01;
		if (s_r.init != 11'h000) s_nxt.init = s_r.init - 11'h001;
		if (s_r.st == DS_RESETTING && s_r.init < 11'h002 && s_r.cs_n) s_nxt.st = DS_RUN;
		if (req_valid && req_ready && req_cmd != CMD_NOP) begin
			s_nxt.cs_n = 1'b0;
			s_nxt.cmd = req_cmd;
			s_nxt.ba = req_ba;
			s_nxt.ap = req_ap;
			s_nxt.ab = req_ab;
			s_nxt.nop = nop_len(req_cmd); // R12 R13 R14 R15
			s_nxt.bfwd = (s_r.st == DS_RUN) && !(req_cmd inside
				{CMD_REF_AB, CMD_MRW, CMD_RESET, CMD_SREF, CMD_DPD});
			if (req_cmd inside {CMD_RD, CMD_WR}) s_nxt.last = req_ba;
			if (req_cmd == CMD_RESET) begin
				s_nxt.st = DS_RESETTING;
				s_nxt.init = INIT5_CYC;
			end else if (req_cmd inside {CMD_SREF, CMD_DPD}) begin
				s_nxt.cke = 1'b0; // R4 R5
				s_nxt.st = (req_cmd == CMD_SREF) ? DS_SREF : DS_DPD;
			end
		end else if (pd_req && s_r.cke && s_r.cs_n && s_r.nop == 8'h00 &&
			(s_r.st == DS_RESETTING || (s_r.st == DS_RUN && pre_ok))) begin
			s_nxt.cke = 1'b0;
			if (s_r.st == DS_RESETTING) begin
				s_nxt.st = DS_RPD; // R6
			end else begin
				s_nxt.st = all_idle ? DS_IPD : DS_APD; // R2 R3
			end
		end else if (!s_r.cke && !pd_req) begin
			s_nxt.cke = 1'b1;
			s_nxt.nop = (s_r.st == DS_SREF) ? XSR_CYC : XP_CYC; // R7 R8 R4
			unique case (s_r.st)
				DS_RPD: s_nxt.st = (s_r.init == 11'h000) ? DS_RUN : DS_RESETTING;
				DS_DPD: begin
					s_nxt.st = DS_POWER_ON; // R5
					s_nxt.nop = XP_CYC;
				end
				default: s_nxt.st = DS_RUN;
			endcase
		end
	end

	// link and tracking registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_r <= '{st: DS_POWER_ON, cke: 1'b1, cs_n: 1'b1, cmd: CMD_NOP, ba: 3'h0,
				ap: 1'b0, ab: 1'b0, bfwd: 1'b0, nop: 8'h00, init: 11'h000, last: 3'h0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// shadow of the device banks, fed the command the device samples
	assign bcmd = s_r.bfwd ? s_r.cmd : CMD_NOP;
	for (genvar g = 0; g < NBANK; g++) begin : g_shadow
		lpbsm_bank u_bank (
			.sys_clk(sys_clk),
			.rst(rst),
			.cmd(bcmd),
			.hit(s_r.bfwd && bank_hit(s_r.cmd, s_r.ab, s_r.ba, 3'(g))),
			.ap(s_r.ap),
			.bst_hit(s_r.bfwd && s_r.cmd == CMD_BST && s_r.last == 3'(g)),
			.state(shadow[g])
		);
	end

	assign link.cke = s_r.cke;
	assign link.cs_n = s_r.cs_n;
	assign link.cmd = s_r.cmd;
	assign link.ba = s_r.ba;
	assign link.ap = s_r.ap;
	assign link.ab = s_r.ab;
	assign ctl_state = s_r.st;
endmodule

// ---- tb/lpbsm_asserts.sv ----
/*
 lpbsm_asserts: concurrent checks on the command link and the device end outputs.
 Assumes one sys_clk domain, rst active high, and a legal controller on the link.
*/
`timescale 1ns/10ps
module lpbsm_asserts (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cke,
	input wire logic cs_n,
	input wire lpbsm_pkg::lpbsm_cmd_t cmd,
	input wire logic [2:0] ba,
	input wire logic ap,
	input wire logic ab,
	input wire lpbsm_pkg::lpbsm_dev_t dev_state,
	input wire lpbsm_pkg::lpbsm_bank_t [lpbsm_pkg::NBANK-1:0] bank_state,
	input wire logic violation
);
	import lpbsm_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// a legal controller never provokes the violation flag
	property p_no_viol; !violation; endproperty
	a_no_viol: assert property (p_no_viol) else $error("violation on legal link");
	// cke fall with nop picks active or idle power down
	property p_apd; $fell(cke) && cs_n && dev_state == DS_RUN && bank_state != '0
		|=> dev_state == DS_APD; endproperty
	a_apd: assert property (p_apd) else $error("no active power down");
	property p_ipd; $fell(cke) && cs_n && dev_state == DS_RUN && bank_state == '0
		|=> dev_state == DS_IPD; endproperty
	a_ipd: assert property (p_ipd) else $error("no idle power down");
	// power down exit with nop returns to run
	property p_pd_exit; dev_state inside {DS_APD, DS_IPD} && $rose(cke) && cs_n
		|=> dev_state == DS_RUN; endproperty
	a_pd_exit: assert property (p_pd_exit) else $error("power down exit wrong");
	property p_sref; $fell(cke) && !cs_n && cmd == CMD_SREF && dev_state == DS_RUN
		|=> dev_state == DS_SREF; endproperty
	a_sref: assert property (p_sref) else $error("self refresh not entered");
	property p_dpd_out; dev_state == DS_DPD && $rose(cke) && cs_n
		|=> dev_state == DS_POWER_ON; endproperty
	a_dpd_out: assert property (p_dpd_out) else $error("deep power down exit wrong");
	property p_rpd; dev_state == DS_RESETTING && $fell(cke) && cs_n
		|=> dev_state == DS_RPD; endproperty
	a_rpd: assert property (p_rpd) else $error("no resetting power down");
	// activate: three edges activating, then active
	property p_act; !cs_n && cmd == CMD_ACT && cke && dev_state == DS_RUN
		&& bank_state[ba] == B_IDLE
		|=> bank_state[$past(ba)] == B_ACTIVATING ##2 bank_state[$past(ba, 3)] == B_ACTIVATING
		##1 bank_state[$past(ba, 4)] == B_ACTIVE; endproperty
	a_act: assert property (p_act) else $error("activate timing wrong");
	property p_pre; !cs_n && cmd == CMD_PRE && !ab && cke && dev_state == DS_RUN
		&& bank_state[ba] inside {B_IDLE, B_ACTIVE}
		|=> bank_state[$past(ba)] == B_PRECHARGING ##2 bank_state[$past(ba, 3)] == B_PRECHARGING
		##1 bank_state[$past(ba, 4)] == B_IDLE; endproperty
	a_pre: assert property (p_pre) else $error("precharge timing wrong");
	// all bank refresh window then run
	property p_refab; !cs_n && cmd == CMD_REF_AB && cke && dev_state == DS_RUN
		|=> dev_state == DS_REF_ALL ##15 dev_state == DS_REF_ALL
		##[1:3] dev_state == DS_RUN; endproperty
	a_refab: assert property (p_refab) else $error("all bank refresh wrong");
	property p_mrw; !cs_n && cmd == CMD_MRW && cke && dev_state == DS_RUN
		|=> dev_state == DS_MRW ##3 dev_state == DS_MRW ##[1:3] dev_state == DS_RUN; endproperty
	a_mrw: assert property (p_mrw) else $error("mode write wrong");
	property p_reset; dev_state == DS_POWER_ON && !cs_n && cmd == CMD_RESET && cke
		&& $past(cke) |=> dev_state == DS_RESETTING; endproperty
	a_reset: assert property (p_reset) else $error("reset not started");
	property p_rd; !cs_n && cmd == CMD_RD && !ap && cke && dev_state == DS_RUN
		&& bank_state[ba] == B_ACTIVE |=> bank_state[$past(ba)] == B_READING; endproperty
	a_rd: assert property (p_rd) else $error("read not started");
endmodule

// ---- tb/lpbsm_tb.sv ----
/*
 lpbsm_tb: controller end and device end joined by one link, plus a second
 device end driven directly to break the command rules.
 Assumes the package timings (RCD 3, RP 3, RFCPB 8, MRR 2, burst 4, AP 4+3).
*/
`timescale 1ns/10ps
module lpbsm_tb;
	import lpbsm_pkg::*;
	logic sys_clk, rst, req_valid, req_ap, req_ab, pd_req, req_ready, violation, violation2;
	lpbsm_cmd_t req_cmd;
	logic [2:0] req_ba;
	lpbsm_dev_t dev_state, ctl_state, dev_state2;
	lpbsm_bank_t [NBANK-1:0] bank_state;
	int errors, check_count;

	lpbsm_if link();
	lpbsm_if link2();
	lpbsm_dev lpbsm_dev_i (.sys_clk(sys_clk), .rst(rst), .link(link), .dev_state(dev_state),
		.bank_state(bank_state), .violation(violation));
	lpbsm_ctl lpbsm_ctl_i (.sys_clk(sys_clk), .rst(rst), .link(link), .req_valid(req_valid),
		.req_cmd(req_cmd), .req_ba(req_ba), .req_ap(req_ap), .req_ab(req_ab),
		.req_ready(req_ready), .pd_req(pd_req), .ctl_state(ctl_state));
	lpbsm_dev lpbsm_dev_i2 (.sys_clk(sys_clk), .rst(rst), .link(link2), .dev_state(dev_state2),
		.bank_state(), .violation(violation2));
	lpbsm_asserts lpbsm_asserts_i (.sys_clk(sys_clk), .rst(rst), .cke(link.cke),
		.cs_n(link.cs_n), .cmd(link.cmd), .ba(link.ba), .ap(link.ap), .ab(link.ab),
		.dev_state(dev_state), .bank_state(bank_state), .violation(violation));

	// 125 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// compare and count
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %0h seen %0h", n, e, g);
		end
	endtask

	// one user request, held until taken; returns once the device has acted
	task automatic req(input lpbsm_cmd_t c, input logic [2:0] b, input logic a, input logic p);
		int i;
		@(negedge sys_clk);
		req_valid = 1'b1;
		req_cmd = c;
		req_ba = b;
		req_ap = a;
		pd_req = p;
		i = 0;
		#1;
		while (req_ready !== 1'b1 && i < 100) begin
			@(negedge sys_clk);
			#1;
			i++;
		end
		if (i == 100) chk("req_ready", 1, req_ready);
		@(negedge sys_clk);
		req_valid = 1'b0;
		req_cmd = CMD_NOP;
		@(negedge sys_clk);
	endtask

	// bounded wait for a device state
	task automatic wait_dev(input lpbsm_dev_t s, input string n);
		int i;
		i = 0;
		while (dev_state !== s && i < 2000) begin
			@(negedge sys_clk);
			i++;
		end
		chk(n, s, dev_state);
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// raw command on the second link, one cycle, then the flag is looked at
	task automatic send2(input lpbsm_cmd_t c, input logic e);
		@(negedge sys_clk);
		link2.cs_n = 1'b0;
		link2.cmd = c;
		@(negedge sys_clk);
		link2.cs_n = 1'b1;
		link2.cmd = CMD_NOP;
		chk("violation2", e, violation2);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// hang guard, well above the under two thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		final_report();
	end

	// main sequence
	initial begin
		rst = 1'b1;
		{req_valid, req_ap, req_ab, pd_req} = 4'h0;
		req_cmd = CMD_NOP;
		req_ba = 3'h0;
		errors = 0;
		check_count = 0;
		{link2.cke, link2.cs_n, link2.ap, link2.ab} = 4'hC;
		link2.cmd = CMD_NOP;
		link2.ba = 3'h0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		chk("dev_state", DS_POWER_ON, dev_state);
		// only a reset is offered to a device that has just powered on
		req_cmd = CMD_ACT;
		#1;
		chk("req_ready", 1'b0, req_ready);
		req(CMD_RESET, 3'h0, 1'b0, 1'b0);
		chk("dev_state", DS_RESETTING, dev_state);
		req(CMD_MRR, 3'h0, 1'b0, 1'b0);
		chk("dev_state", DS_RST_MRR, dev_state);
		tick(2);
		chk("dev_state", DS_RESETTING, dev_state);
		pd_req = 1'b1;
		wait_dev(DS_RPD, "dev_state");
		pd_req = 1'b0;
		wait_dev(DS_RESETTING, "dev_state");
		wait_dev(DS_RUN, "dev_state");
		chk("ctl_state", DS_RUN, ctl_state);
		$display("test init done");
		pd_req = 1'b1;
		wait_dev(DS_IPD, "dev_state");
		pd_req = 1'b0;
		wait_dev(DS_RUN, "dev_state");
		req(CMD_ACT, 3'h2, 1'b0, 1'b0);
		chk("bank2", B_ACTIVATING, bank_state[2]);
		tick(3);
		chk("bank2", B_ACTIVE, bank_state[2]);
		pd_req = 1'b1;
		wait_dev(DS_APD, "dev_state");
		pd_req = 1'b0;
		wait_dev(DS_RUN, "dev_state");
		$display("test power down done");
		req(CMD_RD, 3'h2, 1'b0, 1'b0);
		chk("bank2", B_READING, bank_state[2]);
		req(CMD_BST, 3'h2, 1'b0, 1'b0);
		chk("bank2", B_ACTIVE, bank_state[2]);
		req(CMD_WR, 3'h2, 1'b0, 1'b0);
		chk("bank2", B_WRITING, bank_state[2]);
		tick(4);
		chk("bank2", B_ACTIVE, bank_state[2]);
		req(CMD_MRR, 3'h2, 1'b0, 1'b0);
		chk("bank2", B_MRR_ACT, bank_state[2]);
		tick(2);
		chk("bank2", B_ACTIVE, bank_state[2]);
		req(CMD_RD, 3'h2, 1'b1, 1'b0);
		chk("bank2", B_RD_AP, bank_state[2]);
		tick(7);
		chk("bank2", B_IDLE, bank_state[2]);
		req(CMD_PRE, 3'h5, 1'b0, 1'b0);
		chk("bank5", B_PRECHARGING, bank_state[5]);
		tick(3);
		chk("bank5", B_IDLE, bank_state[5]);
		// precharge of every bank at once, all of them idle
		req_ab = 1'b1;
		req(CMD_PRE, 3'h0, 1'b0, 1'b0);
		req_ab = 1'b0;
		chk("bank7", B_PRECHARGING, bank_state[7]);
		tick(3);
		chk("bank7", B_IDLE, bank_state[7]);
		req(CMD_REF_PB, 3'h1, 1'b0, 1'b0);
		chk("bank1", B_REFRESHING, bank_state[1]);
		tick(8);
		chk("bank1", B_IDLE, bank_state[1]);
		req(CMD_MRR, 3'h0, 1'b0, 1'b0);
		chk("bank0", B_MRR_IDLE, bank_state[0]);
		tick(2);
		chk("bank0", B_IDLE, bank_state[0]);
		req(CMD_REF_AB, 3'h0, 1'b0, 1'b0);
		chk("dev_state", DS_REF_ALL, dev_state);
		wait_dev(DS_RUN, "dev_state");
		req(CMD_MRW, 3'h0, 1'b0, 1'b0);
		chk("dev_state", DS_MRW, dev_state);
		wait_dev(DS_RUN, "dev_state");
		$display("test bank commands done");
		req(CMD_SREF, 3'h0, 1'b0, 1'b1);
		chk("dev_state", DS_SREF, dev_state);
		chk("ctl_state", DS_SREF, ctl_state);
		pd_req = 1'b0;
		wait_dev(DS_RUN, "dev_state");
		req(CMD_DPD, 3'h0, 1'b0, 1'b1);
		chk("dev_state", DS_DPD, dev_state);
		pd_req = 1'b0;
		wait_dev(DS_POWER_ON, "dev_state");
		chk("ctl_state", DS_POWER_ON, ctl_state);
		$display("test low power done");
		send2(CMD_ACT, 1'b1);
		chk("dev_state2", DS_POWER_ON, dev_state2);
		send2(CMD_RESET, 1'b0);
		send2(CMD_MRR, 1'b1);
		$display("test violations done");
		final_report();
	end
endmodule
